// [bench/analog_core_model.sv]
`timescale 1ns/1ns
module analog_core_model
  import ldo_chg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [NUM_RAW-1:0] want,
  output logic [NUM_CH-1:0] power_good_raw,
  output logic [NUM_CH-1:0] fault_raw,
  output logic precharge_timeout_raw,
  output logic total_timeout_raw,
  output logic battery_temp_ok_raw,
  output logic charger_input_supply_ok_raw,
  output logic end_of_charge_raw
);
  // Levels settle one cycle after a request, like a slow analog flag
  logic [NUM_RAW-1:0] lv = '0;
  always @(posedge sys_clk) begin
    lv <= want;
  end
  assign power_good_raw = lv[R_PG_LSB +: NUM_CH];
  assign fault_raw = lv[R_FLT_LSB +: NUM_CH];
  assign precharge_timeout_raw = lv[R_PRE_TO];
  assign total_timeout_raw = lv[R_TOT_TO];
  assign battery_temp_ok_raw = lv[R_TEMP_OK];
  assign charger_input_supply_ok_raw = lv[R_IN_OK];
  assign end_of_charge_raw = lv[R_EOC];
endmodule : analog_core_model

// [bench/ldo_chg_sva.sv]
`timescale 1ns/1ns
module ldo_chg_sva
  import ldo_chg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic [NUM_CH-1:0] ldo_enable,
  input wire logic [NUM_CH-1:0] output_discharge_active,
  input wire logic [NUM_CH-1:0] low_quiescent_mode,
  input wire logic [NUM_CH-1:0][DLY_W-1:0] turn_on_delay_select,
  input wire logic [VSEL_W-1:0] output_voltage_select,
  input wire logic charge_suspend,
  input wire logic [SEL_W-1:0] total_timeout_select,
  input wire logic [SEL_W-1:0] precondition_timeout_select,
  input wire logic [SEL_W-1:0] input_overvoltage_select
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // A write lands only on the access edge with the low lane strobed
  sequence s_wr(a);
    psel && penable && pwrite && pstrb[0] && paddr == a;
  endsequence
  sequence s_setup;
    psel && !penable;
  endsequence
  AST_ON: assert property (s_wr(ADDR_LDO_D_CTRL) |=> ldo_enable[1] == $past(pwdata[B_ON]))
    else $error("enable bit not applied");
  AST_HOLD: assert property (s_setup |=> $stable(ldo_enable))
    else $error("enable moved without a write");
  AST_DIS: assert property (s_wr(ADDR_LDO_D_CTRL) |=>
    output_discharge_active[1] == $past(pwdata[B_DIS] & ~pwdata[B_ON]))
    else $error("discharge wrong");
  AST_LOW_QUIESCENT_MODE: assert property (s_wr(ADDR_LDO_C_CTRL) |=>
    low_quiescent_mode[0] == $past(pwdata[B_LOW_QUIESCENT_MODE]))
    else $error("low quiescent wrong");
  AST_DLY: assert property (s_wr(ADDR_LDO_D_CTRL) |=>
    turn_on_delay_select[1] == $past(pwdata[4:2]))
    else $error("delay select wrong");
  AST_VSEL: assert property (s_wr(ADDR_LDO_D_VSEL) |=>
    output_voltage_select == $past(pwdata[5:0]))
    else $error("voltage select wrong");
  AST_RDV: assert property (s_setup ##1 (penable && !pwrite && paddr == ADDR_LDO_D_VSEL)
    |-> prdata[7:6] == 2'b00)
    else $error("reserved voltage bits read back");
  AST_CFG: assert property (s_wr(ADDR_CHG_CFG) |=> {charge_suspend, total_timeout_select,
    precondition_timeout_select, input_overvoltage_select} ==
    $past({pwdata[7], pwdata[5:0]}))
    else $error("charger config wrong");
endmodule : ldo_chg_sva

// [bench/tb_top.sv]
`timescale 1ns/1ns
module tb_top
  import ldo_chg_pkg::*;
;
  logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic [NUM_RAW-1:0] want = '0;
  logic pready, pslverr, charge_suspend, host_irq_b, precharge_timeout_raw, total_timeout_raw;
  logic battery_temp_ok_raw, charger_input_supply_ok_raw, end_of_charge_raw;
  logic [NUM_CH-1:0] ldo_enable, output_discharge_active, low_quiescent_mode;
  logic [NUM_CH-1:0] power_good_raw, fault_raw;
  logic [NUM_CH-1:0][DLY_W-1:0] turn_on_delay_select;
  logic [VSEL_W-1:0] output_voltage_select;
  logic [SEL_W-1:0] total_timeout_select, precondition_timeout_select, input_overvoltage_select;
  logic [32:0] exp_q[$];
  logic [7:0] r;
  int n_errors = 0, total_checks = 0, cyc = 0;
  logic [ADDR_W-1:0] amap[6] = '{ADDR_LDO_C_CTRL, ADDR_LDO_D_VSEL, ADDR_LDO_D_CTRL,
    ADDR_CHG_RSVD, ADDR_CHG_CFG, ADDR_CHG_STAT};
  ldo_chg_ctrl_regs u_ldo_chg_ctrl_regs (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .power_good_raw, .fault_raw,
    .precharge_timeout_raw, .total_timeout_raw, .battery_temp_ok_raw,
    .charger_input_supply_ok_raw, .end_of_charge_raw, .ldo_enable, .output_discharge_active,
    .low_quiescent_mode, .turn_on_delay_select, .output_voltage_select, .charge_suspend,
    .total_timeout_select, .precondition_timeout_select, .input_overvoltage_select,
    .host_irq_b);
  analog_core_model u_analog_core_model (.sys_clk, .want, .power_good_raw, .fault_raw,
    .precharge_timeout_raw, .total_timeout_raw, .battery_temp_ok_raw,
    .charger_input_supply_ok_raw, .end_of_charge_raw);
  always #25 sys_clk = ~sys_clk;
  task finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task check(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // Read expectations are queued before setup so the monitor never runs dry
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [32:0] e);
    if (!w) exp_q.push_back(e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [ADDR_W-1:0] a, input logic [7:0] b);
    apb(1'b0, a, 8'h00, {25'h0000000, b});
  endtask : rd
  task wait_irq(input logic v);
    for (int i = 0; i < 20 && host_irq_b !== v; i++) @(posedge sys_clk);
    @(negedge sys_clk);
    check({32'h0, host_irq_b}, {32'h0, v});
  endtask : wait_irq
  always @(posedge sys_clk) begin
    cyc++;
    if (psel && penable && !pwrite && pready) check({pslverr, prdata}, exp_q.pop_front());
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(5046));
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    check({23'h0, host_irq_b, ldo_enable, output_voltage_select, charge_suspend}, 33'h200);
    foreach (amap[i]) rd(amap[i], 8'h00);
    $display("reset test done");
    // Channels alternate so both discharge and delay outputs are seen
    for (int i = 0; i < 8; i++) begin
      r = (i < 2) ? 8'h5C : 8'($urandom);
      apb(1'b1, i[0] ? ADDR_LDO_D_CTRL : ADDR_LDO_C_CTRL, r, 33'h0);
      @(negedge sys_clk);
      check({27'h0, ldo_enable[i[0]], output_discharge_active[i[0]],
        low_quiescent_mode[i[0]], turn_on_delay_select[i[0]]},
        {27'h0, r[7], r[6] & ~r[7], r[5], r[4:2]});
      rd(i[0] ? ADDR_LDO_D_CTRL : ADDR_LDO_C_CTRL, {r[7:1], 1'b0});
    end
    want[R_PG_LSB + 1] <= 1'b1;
    apb(1'b1, ADDR_LDO_C_CTRL, 8'hA0, 33'h0);
    apb(1'b1, ADDR_LDO_D_CTRL, 8'h00, 33'h0);
    rd(ADDR_LDO_D_CTRL, 8'h01);
    rd(ADDR_LDO_C_CTRL, 8'hA0);
    check({31'h0, ldo_enable[0], low_quiescent_mode[0]}, 33'h3);
    apb(1'b1, ADDR_LDO_D_VSEL, 8'hFF, 33'h0);
    rd(ADDR_LDO_D_VSEL, 8'h3F);
    $display("regulator test done");
    r = 8'($urandom);
    apb(1'b1, ADDR_CHG_CFG, r, 33'h0);
    @(negedge sys_clk);
    check({26'h0, charge_suspend, total_timeout_select, precondition_timeout_select,
      input_overvoltage_select}, {26'h0, r[7], r[5:0]});
    pstrb <= 4'h0;
    apb(1'b1, ADDR_CHG_CFG, ~r, 33'h0);
    pstrb <= 4'hF;
    rd(ADDR_CHG_CFG, r);
    apb(1'b1, ADDR_CHG_RSVD, 8'h5A, 33'h0);
    rd(ADDR_CHG_RSVD, 8'h5A);
    apb(1'b0, 10'h1E8, 8'h00, {1'b1, 32'h0});
    $display("charger config test done");
    apb(1'b1, ADDR_LDO_D_CTRL, 8'h02, 33'h0);
    want[R_FLT_LSB + 1] <= 1'b1;
    wait_irq(1'b0);
    apb(1'b1, ADDR_LDO_D_CTRL, 8'h00, 33'h0);
    wait_irq(1'b1);
    want[R_FLT_LSB + 1] <= 1'b0;
    want[R_IN_OK] <= 1'b1;
    apb(1'b1, ADDR_CHG_IRQ_EN, 8'h08, 33'h0);
    apb(1'b1, ADDR_CHG_STAT, 8'h80, 33'h0);
    want[R_PRE_TO] <= 1'b1;
    wait_irq(1'b0);
    rd(ADDR_CHG_STAT, 8'h8A);
    rd(ADDR_CHG_STAT, 8'h0A);
    wait_irq(1'b1);
    want[R_IN_OK] <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd(ADDR_CHG_STAT, 8'h00);
    want[R_IN_OK] <= 1'b1;
    apb(1'b1, ADDR_CHG_IRQ_EN, 8'h10, 33'h0);
    apb(1'b1, ADDR_CHG_STAT, 8'h00, 33'h0);
    want[R_EOC] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    wait_irq(1'b1);
    want[R_EOC] <= 1'b0;
    apb(1'b1, ADDR_CHG_STAT, 8'h10, 33'h0);
    want[R_EOC] <= 1'b1;
    wait_irq(1'b0);
    rd(ADDR_CHG_STAT, 8'h1B);
    apb(1'b1, ADDR_CHG_IRQ_EN, 8'h42, 33'h0);
    apb(1'b1, ADDR_CHG_STAT, 8'h60, 33'h0);
    want[R_TEMP_OK] <= 1'b1;
    wait_irq(1'b0);
    rd(ADDR_CHG_STAT, 8'h4F);
    wait_irq(1'b1);
    want[R_IN_OK] <= 1'b0;
    wait_irq(1'b0);
    rd(ADDR_CHG_STAT, 8'h20);
    $display("interrupt test done");
    finish_test();
  end
endmodule : tb_top
bind ldo_chg_ctrl_regs ldo_chg_sva u_ldo_chg_sva (.sys_clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .ldo_enable, .output_discharge_active, .low_quiescent_mode,
  .turn_on_delay_select, .output_voltage_select, .charge_suspend, .total_timeout_select,
  .precondition_timeout_select, .input_overvoltage_select);

// [rtl/ldo_chg_ctrl_regs.sv]
// Local design decision: the APB register port.
`timescale 1ns/1ns
module ldo_chg_ctrl_regs
  import ldo_chg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CH-1:0] power_good_raw,
  input wire logic [NUM_CH-1:0] fault_raw,
  input wire logic precharge_timeout_raw,
  input wire logic total_timeout_raw,
  input wire logic battery_temp_ok_raw,
  input wire logic charger_input_supply_ok_raw,
  input wire logic end_of_charge_raw,
  output logic [NUM_CH-1:0] ldo_enable,
  output logic [NUM_CH-1:0] output_discharge_active,
  output logic [NUM_CH-1:0] low_quiescent_mode,
  output logic [NUM_CH-1:0][DLY_W-1:0] turn_on_delay_select,
  output logic [VSEL_W-1:0] output_voltage_select,
  output logic charge_suspend,
  output logic [SEL_W-1:0] total_timeout_select,
  output logic [SEL_W-1:0] precondition_timeout_select,
  output logic [SEL_W-1:0] input_overvoltage_select,
  output logic host_irq_b
);

  // Channel 0 is the register at 0x61, channel 1 the one at 0x65
  typedef struct packed {
    logic [NUM_CH-1:0][6:0] ctrl;
    logic [VSEL_W-1:0] vsel;
    logic [7:0] rsvd_cfg;
    logic [7:0] chg_cfg;
    logic [7:0] irq_en;
    logic [3:0] arm;
    logic [3:0] pend;
    logic [NUM_CH-1:0] dsch;
    logic [31:0] rdata;
    logic slverr;
    logic irq_b;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [NUM_RAW-1:0] raw;
  logic [NUM_RAW-1:0] lvl;
  logic [NUM_RAW-1:0] rise;
  logic [NUM_RAW-1:0] fall;

  // Pins from the analog core cross into this clock first
  assign raw = {fault_raw, power_good_raw, end_of_charge_raw,
                charger_input_supply_ok_raw, battery_temp_ok_raw,
                total_timeout_raw, precharge_timeout_raw};

  status_sync #(
    .W(NUM_RAW)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in(raw),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  logic in_ok;
  logic [NUM_CH-1:0] pg;
  logic [NUM_CH-1:0] flt;
  logic timer_expired;
  logic temp_ok;
  logic eoc;

  assign in_ok = lvl[R_IN_OK];
  assign pg = lvl[R_PG_LSB +: NUM_CH];
  assign flt = lvl[R_FLT_LSB +: NUM_CH];

  // Marked status is only trusted with the input supply in range
  assign timer_expired = in_ok & (lvl[R_PRE_TO] | lvl[R_TOT_TO]);
  assign temp_ok = in_ok & lvl[R_TEMP_OK];
  assign eoc = in_ok & lvl[R_EOC];

  logic setup;
  logic access;
  logic wr_ok;
  logic rd_done;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr_ok = access & pwrite & ~s_q.slverr & pstrb[0];
  assign rd_done = access & ~pwrite & ~s_q.slverr;

  logic [7:0] rd_byte;
  logic miss;

  // Read data and the error answer are prepared in the setup cycle
  always_comb begin
    rd_byte = 8'h00;
    miss = 1'b0;
    case (paddr)
      ADDR_LDO_C_CTRL: begin
        rd_byte = {s_q.ctrl[0], pg[0]};
      end
      ADDR_LDO_D_VSEL: begin
        rd_byte = {2'b00, s_q.vsel};
      end
      ADDR_LDO_D_CTRL: begin
        rd_byte = {s_q.ctrl[1], pg[1]};
      end
      ADDR_CHG_RSVD: begin
        rd_byte = s_q.rsvd_cfg;
      end
      ADDR_CHG_CFG: begin
        rd_byte = s_q.chg_cfg;
      end
      ADDR_CHG_STAT: begin
        rd_byte = {s_q.pend, timer_expired, temp_ok, in_ok, eoc};
      end
      ADDR_CHG_IRQ_EN: begin
        rd_byte = s_q.irq_en;
      end
      default: begin
        miss = 1'b1;
      end
    endcase
  end

  logic [3:0] ev;
  logic [7:0] en;

  assign en = s_q.irq_en;

  // Events only count when their enable is set
  always_comb begin
    ev = 4'h0;
    ev[3] = in_ok & ((rise[R_PRE_TO] & en[E_PRE])
            | (rise[R_TOT_TO] & en[E_TOT]));
    ev[2] = in_ok & ((rise[R_TEMP_OK] & en[E_TEMP_IN])
            | (fall[R_TEMP_OK] & en[E_TEMP_OUT]));
    ev[1] = (rise[R_IN_OK] & en[E_IN_CON])
            | (fall[R_IN_OK] & en[E_IN_DIS]);
    ev[0] = in_ok & ((rise[R_EOC] & en[E_EOC_IN])
            | (fall[R_EOC] & en[E_EOC_OUT]));
  end

  logic [3:0] pend_kept;
  logic [NUM_CH-1:0] fault_irq;

  always_comb begin
    s_d = s_q;
    pend_kept = s_q.pend;
    fault_irq = flt & {s_q.ctrl[1][B_FLT_EN-1], s_q.ctrl[0][B_FLT_EN-1]};
    if (setup) begin
      s_d.rdata = {24'h000000, rd_byte};
      s_d.slverr = miss;
    end
    if (wr_ok) begin
      case (paddr)
        ADDR_LDO_C_CTRL: begin
          s_d.ctrl[0] = pwdata[7:1];
        end
        ADDR_LDO_D_VSEL: begin
          s_d.vsel = pwdata[VSEL_W-1:0];
        end
        ADDR_LDO_D_CTRL: begin
          s_d.ctrl[1] = pwdata[7:1];
        end
        ADDR_CHG_RSVD: begin
          s_d.rsvd_cfg = pwdata[7:0];
        end
        ADDR_CHG_CFG: begin
          s_d.chg_cfg = pwdata[7:0];
        end
        ADDR_CHG_STAT: begin
          s_d.arm = pwdata[7:B_ARM_LSB];
        end
        ADDR_CHG_IRQ_EN: begin
          s_d.irq_en = pwdata[7:0];
        end
        default: begin
          s_d.arm = s_q.arm;
        end
      endcase
    end
    // Reading the status clears only the pending bits it reported
    if (rd_done && paddr == ADDR_CHG_STAT) begin
      pend_kept = s_q.pend & ~s_q.rdata[7:B_ARM_LSB];
    end
    // Disarming drops a pending bit and blocks a new event; an armed new event still beats the read clear
    s_d.pend = (pend_kept & s_d.arm) | (ev & s_d.arm);
    for (int i = 0; i < NUM_CH; i++) begin
      s_d.dsch[i] = s_d.ctrl[i][B_DIS-1] & ~s_d.ctrl[i][B_ON-1];
    end
    s_d.irq_b = ~((|s_d.pend) | (|fault_irq));
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q.ctrl <= {NUM_CH{RST_LDO_CTRL}};
      s_q.vsel <= RST_VSEL;
      s_q.rsvd_cfg <= RST_CHG_RSVD;
      s_q.chg_cfg <= RST_CHG_CFG;
      s_q.irq_en <= RST_CHG_IRQ_EN;
      s_q.arm <= RST_ARM;
      s_q.pend <= 4'h0;
      s_q.dsch <= '0;
      s_q.rdata <= 32'h00000000;
      s_q.slverr <= 1'b0;
      s_q.irq_b <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero wait states: every access phase completes on its first edge
  assign pready = 1'b1;
  assign prdata = s_q.rdata;
  assign pslverr = s_q.slverr & access;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign ldo_enable[g] = s_q.ctrl[g][B_ON-1];
      assign output_discharge_active[g] = s_q.dsch[g];
      assign low_quiescent_mode[g] = s_q.ctrl[g][B_LOW_QUIESCENT_MODE-1];
      assign turn_on_delay_select[g] = s_q.ctrl[g][B_DLY_LSB-1 +: DLY_W];
    end
  endgenerate

  assign output_voltage_select = s_q.vsel;
  assign charge_suspend = s_q.chg_cfg[B_SUSPEND];
  assign total_timeout_select = s_q.chg_cfg[B_TOT_LSB +: SEL_W];
  assign precondition_timeout_select = s_q.chg_cfg[B_PRE_LSB +: SEL_W];
  assign input_overvoltage_select = s_q.chg_cfg[B_OVP_LSB +: SEL_W];
  assign host_irq_b = s_q.irq_b;

endmodule : ldo_chg_ctrl_regs

// [rtl/ldo_chg_pkg.sv]
package ldo_chg_pkg;

  localparam int ADDR_W = 10;
  localparam int VSEL_W = 6;
  localparam int DLY_W = 3;
  localparam int SEL_W = 2;
  localparam int NUM_CH = 2;
  localparam int NUM_RAW = 9;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_LDO_C_CTRL = 8'h61;
  localparam logic [7:0] IDX_LDO_D_VSEL = 8'h64;
  localparam logic [7:0] IDX_LDO_D_CTRL = 8'h65;
  localparam logic [7:0] IDX_CHG_RSVD = 8'h70;
  localparam logic [7:0] IDX_CHG_CFG = 8'h71;
  localparam logic [7:0] IDX_CHG_STAT = 8'h78;
  localparam logic [7:0] IDX_CHG_IRQ_EN = 8'h79;

  localparam logic [ADDR_W-1:0] ADDR_LDO_C_CTRL = {IDX_LDO_C_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_LDO_D_VSEL = {IDX_LDO_D_VSEL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_LDO_D_CTRL = {IDX_LDO_D_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CHG_RSVD = {IDX_CHG_RSVD, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CHG_CFG = {IDX_CHG_CFG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CHG_STAT = {IDX_CHG_STAT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CHG_IRQ_EN = {IDX_CHG_IRQ_EN, 2'b00};

  // Regulator control fields
  localparam int B_ON = 7;
  localparam int B_DIS = 6;
  localparam int B_LOW_QUIESCENT_MODE = 5;
  localparam int B_DLY_LSB = 2;
  localparam int B_FLT_EN = 1;
  localparam int B_OK = 0;

  // Charger configuration fields
  localparam int B_SUSPEND = 7;
  localparam int B_TOT_LSB = 4;
  localparam int B_PRE_LSB = 2;
  localparam int B_OVP_LSB = 0;

  // Charger status: four arm/status bits on top, live levels below
  localparam int B_ARM_LSB = 4;
  localparam int ST_TIMER = 3;
  localparam int ST_TEMP = 2;
  localparam int ST_INPUT = 1;
  localparam int ST_CHARGE = 0;

  // Charger interrupt enable fields
  localparam int E_TOT = 7;
  localparam int E_TEMP_IN = 6;
  localparam int E_IN_CON = 5;
  localparam int E_EOC_IN = 4;
  localparam int E_PRE = 3;
  localparam int E_TEMP_OUT = 2;
  localparam int E_IN_DIS = 1;
  localparam int E_EOC_OUT = 0;

  // Positions of the analog status inputs in the synchroniser vector
  localparam int R_PRE_TO = 0;
  localparam int R_TOT_TO = 1;
  localparam int R_TEMP_OK = 2;
  localparam int R_IN_OK = 3;
  localparam int R_EOC = 4;
  localparam int R_PG_LSB = 5;
  localparam int R_FLT_LSB = 7;

  // Values after reset
  localparam logic [6:0] RST_LDO_CTRL = 7'h00;
  localparam logic [VSEL_W-1:0] RST_VSEL = 6'h00;
  localparam logic [7:0] RST_CHG_RSVD = 8'h00;
  localparam logic [7:0] RST_CHG_CFG = 8'h00;
  localparam logic [7:0] RST_CHG_IRQ_EN = 8'h00;
  localparam logic [3:0] RST_ARM = 4'h0;

endpackage : ldo_chg_pkg

// [rtl/status_sync.sv]
`timescale 1ns/1ns
module status_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] prev;
  } sync_t;

  sync_t s_q;
  sync_t s_d;

  // First stage feeds only the second stage
  always_comb begin
    s_d = s_q;
    s_d.s1 = async_in;
    s_d.s2 = s_q.s1;
    s_d.prev = s_q.s2;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.s2;
  assign rise = s_q.s2 & ~s_q.prev;
  assign fall = ~s_q.s2 & s_q.prev;

endmodule : status_sync
